// [ptic_pkg.sv]
// Package with constants, modes, states and carrier structs for the pattern trigger block.
package ptic_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned HEARTBEAT_MS = 250;
  localparam int unsigned HEARTBEAT_CYCLES = CLK_HZ / 1000 * HEARTBEAT_MS;
  localparam int unsigned PWM_BITS = 8;
  localparam int unsigned PAT_BITS = 6;
  localparam int unsigned EXPO_BITS = 16;
  localparam int unsigned NUM_CH = 3;
  localparam logic [1:0] CH_RED = 2'h0;
  localparam logic [1:0] CH_GREEN = 2'h1;
  localparam logic [1:0] CH_BLUE = 2'h2;
  localparam logic [PAT_BITS-1:0] PAT_FIRST = 6'h00;
  localparam logic [PAT_BITS-1:0] PAT_STEP_ONE = 6'h01;
  localparam logic [PAT_BITS-1:0] PAT_STEP_TWO = 6'h02;
  localparam logic [EXPO_BITS-1:0] EXPO_ZERO = 16'h0000;
  localparam logic [PWM_BITS-1:0] PWM_ZERO = 8'h00;

  typedef enum logic {
    PTIC_MODE_ADVANCE = 1'b0,
    PTIC_MODE_ALTERNATE = 1'b1
  } ptic_mode_e;

  typedef enum logic [1:0] {
    PTIC_ST_IDLE = 2'b00,
    PTIC_ST_EXPOSE = 2'b01,
    PTIC_ST_GAP = 2'b11
  } ptic_state_e;

  typedef struct packed {
    logic [PWM_BITS-1:0] red;
    logic [PWM_BITS-1:0] green;
    logic [PWM_BITS-1:0] blue;
  } ptic_duty_s;

  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } ptic_chan_s;
endpackage : ptic_pkg

// [ptic_top.sv]
// Pattern trigger sequencing, exposure strobes and illumination control.
// Contract
// - Three colour channels, each with own enable and own current PWM output.
// - Each channel PWM duty cycle sets the external driver's LED current.
// - Heartbeat output toggles continuously while the system runs correctly.
// - Fault indicator output low during a fault, high otherwise.
// - Advance trigger steps to next pattern or alternates two patterns by mode.
// - Hold trigger pauses or resumes the sequence, or steps it by two, by mode.
// - Exposure strobe high exactly while a pattern is exposed, else low.
// - First frame flag high while the first pattern of the sequence shows.
`timescale 1ns/1ps
module ptic_top
  import ptic_pkg::*;
#(
  parameter int unsigned HEARTBEAT_HALF = HEARTBEAT_CYCLES,
  parameter int unsigned PAT_W = PAT_BITS,
  parameter int unsigned EXP_W = EXPO_BITS
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic mode_alternate_in,
  input wire logic hold_steps_in,
  input wire logic [PAT_W-1:0] last_pattern_in,
  input wire logic [EXP_W-1:0] exposure_cycles_in,
  input wire ptic_duty_s duty_in,
  input wire ptic_chan_s channel_select_in,
  input wire logic fault_in,
  input wire logic advance_trigger_in,
  input wire logic hold_trigger_in,
  output logic red_channel_enable_out,
  output logic green_channel_enable_out,
  output logic blue_channel_enable_out,
  output logic red_current_pwm_out,
  output logic green_current_pwm_out,
  output logic blue_current_pwm_out,
  output logic heartbeat_out,
  output logic fault_led_out,
  output logic exposure_strobe_out,
  output logic first_frame_flag_out,
  output logic [PAT_W-1:0] pattern_index_out
);

  function automatic logic [PAT_W-1:0] wrap_add(input logic [PAT_W-1:0] idx,
                                                input logic [PAT_W-1:0] step,
                                                input logic [PAT_W-1:0] last);
    logic [PAT_W:0] sum;
    sum = {1'b0, idx} + {1'b0, step};
    if (sum > {1'b0, last}) begin
      wrap_add = PAT_W'(sum - {1'b0, last} - 1'b1);
    end else begin
      wrap_add = sum[PAT_W-1:0];
    end
  endfunction : wrap_add

  // Two flip-flop synchronisers; only stage two feeds the edge detectors.
  logic [1:0] adv_sync_q, adv_sync_d;
  logic [1:0] hold_sync_q, hold_sync_d;
  logic adv_prev_q, adv_prev_d;
  logic hold_prev_q, hold_prev_d;
  logic fault_s1_q, fault_s2_q;
  logic adv_edge, hold_edge;

  always_comb begin
    adv_sync_d = {adv_sync_q[0], advance_trigger_in};
    hold_sync_d = {hold_sync_q[0], hold_trigger_in};
    adv_prev_d = adv_sync_q[1];
    hold_prev_d = hold_sync_q[1];
    adv_edge = adv_sync_q[1] & ~adv_prev_q;
    hold_edge = hold_sync_q[1] & ~hold_prev_q;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      adv_sync_q <= 2'b00;
      hold_sync_q <= 2'b00;
      adv_prev_q <= 1'b0;
      hold_prev_q <= 1'b0;
      fault_s1_q <= 1'b0;
      fault_s2_q <= 1'b0;
    end else begin
      adv_sync_q <= adv_sync_d;
      hold_sync_q <= hold_sync_d;
      adv_prev_q <= adv_prev_d;
      hold_prev_q <= hold_prev_d;
      fault_s1_q <= fault_in;
      fault_s2_q <= fault_s1_q;
    end
  end

  // Sequencer: each accepted trigger with non-zero exposure_cycles_in starts one exposure of the new pattern.
  ptic_state_e state_q, state_d;
  logic [PAT_W-1:0] pat_q, pat_d;
  logic [EXP_W-1:0] cnt_q, cnt_d;
  logic paused_q, paused_d;
  logic strobe_q, strobe_d;
  logic first_q, first_d;
  logic start;

  always_comb begin
    state_d = state_q;
    pat_d = pat_q;
    cnt_d = cnt_q;
    paused_d = paused_q;
    start = 1'b0;
    if (hold_edge && !hold_steps_in) begin
      paused_d = ~paused_q;
    end
    // An advance in the cycle of a double step is folded into it, so neither is lost.
    if (hold_edge && hold_steps_in && !paused_q) begin
      pat_d = wrap_add(pat_q,
                       adv_edge ? PAT_W'(PAT_STEP_TWO + PAT_STEP_ONE) : PAT_W'(PAT_STEP_TWO),
                       last_pattern_in);
      start = 1'b1;
    end else if (adv_edge && !paused_q) begin
      if (mode_alternate_in == PTIC_MODE_ALTERNATE) begin
        pat_d = (pat_q == PAT_FIRST) ? PAT_STEP_ONE : PAT_FIRST;
      end else begin
        pat_d = wrap_add(pat_q, PAT_STEP_ONE, last_pattern_in);
      end
      start = 1'b1;
    end
    case (state_q)
      PTIC_ST_IDLE, PTIC_ST_GAP: begin
        state_d = PTIC_ST_IDLE;
        if (start && exposure_cycles_in != EXPO_ZERO) begin
          state_d = PTIC_ST_EXPOSE;
          cnt_d = exposure_cycles_in;
        end
      end
      PTIC_ST_EXPOSE: begin
        if (start && exposure_cycles_in != EXPO_ZERO) begin
          cnt_d = exposure_cycles_in;
        end else if (cnt_q == EXPO_ZERO + 1'b1) begin
          state_d = PTIC_ST_GAP;
          cnt_d = EXPO_ZERO;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = PTIC_ST_IDLE;
        cnt_d = EXPO_ZERO;
      end
    endcase
    strobe_d = (state_d == PTIC_ST_EXPOSE);
    first_d = (pat_d == PAT_FIRST);
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_q <= PTIC_ST_IDLE;
      pat_q <= PAT_FIRST;
      cnt_q <= EXPO_ZERO;
      paused_q <= 1'b0;
      strobe_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      state_q <= state_d;
      pat_q <= pat_d;
      cnt_q <= cnt_d;
      paused_q <= paused_d;
      strobe_q <= strobe_d;
      first_q <= first_d;
    end
  end

  // Illumination: one shared free-running PWM counter keeps channels phase aligned.
  logic [PWM_BITS-1:0] pwm_cnt_q, pwm_cnt_d;
  ptic_chan_s pwm_q, pwm_d, en_q, en_d;
  logic [31:0] hb_cnt_q, hb_cnt_d;
  logic hb_q, hb_d, fled_q, fled_d;

  always_comb begin
    pwm_cnt_d = pwm_cnt_q + 1'b1;
    pwm_d.red = (pwm_cnt_q < duty_in.red);
    pwm_d.green = (pwm_cnt_q < duty_in.green);
    pwm_d.blue = (pwm_cnt_q < duty_in.blue);
    en_d = fault_s2_q ? '0 : channel_select_in;
    hb_cnt_d = hb_cnt_q + 1'b1;
    hb_d = hb_q;
    // The heartbeat freezes during a fault, so a stopped blink also signals trouble.
    if (fault_s2_q) begin
      hb_cnt_d = hb_cnt_q;
    end else if (hb_cnt_q >= HEARTBEAT_HALF - 1) begin
      hb_cnt_d = '0;
      hb_d = ~hb_q;
    end
    fled_d = ~fault_s2_q;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pwm_cnt_q <= PWM_ZERO;
      pwm_q <= '0;
      en_q <= '0;
      hb_cnt_q <= '0;
      hb_q <= 1'b0;
      fled_q <= 1'b1;
    end else begin
      pwm_cnt_q <= pwm_cnt_d;
      pwm_q <= pwm_d;
      en_q <= en_d;
      hb_cnt_q <= hb_cnt_d;
      hb_q <= hb_d;
      fled_q <= fled_d;
    end
  end

  always_comb begin
    red_channel_enable_out = en_q.red;
    green_channel_enable_out = en_q.green;
    blue_channel_enable_out = en_q.blue;
    red_current_pwm_out = pwm_q.red;
    green_current_pwm_out = pwm_q.green;
    blue_current_pwm_out = pwm_q.blue;
    heartbeat_out = hb_q;
    fault_led_out = fled_q;
    exposure_strobe_out = strobe_q;
    first_frame_flag_out = first_q;
    pattern_index_out = pat_q;
  end

  a_fault_led_low: assert property (@(posedge clock_in) disable iff (reset_in)
    fault_s2_q |=> !fault_led_out) else $error("fault led not off during fault");
  a_fault_chan_off: assert property (@(posedge clock_in) disable iff (reset_in)
    fault_s2_q |=> !(red_channel_enable_out | green_channel_enable_out | blue_channel_enable_out))
    else $error("channel enabled during fault");
  a_pwm_zero_duty: assert property (@(posedge clock_in) disable iff (reset_in)
    (duty_in.red == PWM_ZERO) |=> !red_current_pwm_out) else $error("red pwm high at zero duty");
  a_edge_once: assert property (@(posedge clock_in) disable iff (reset_in)
    adv_edge |=> !adv_edge) else $error("advance edge seen twice");
  a_advance_step: assert property (@(posedge clock_in) disable iff (reset_in)
    (adv_edge && !hold_edge && !paused_q && !mode_alternate_in && pat_q < last_pattern_in)
    |=> pattern_index_out == $past(pat_q) + 1'b1) else $error("advance did not step by one");
  a_pause_freeze: assert property (@(posedge clock_in) disable iff (reset_in)
    (paused_q && !hold_edge) |=> $stable(pat_q)) else $error("pattern moved while paused");
  a_strobe_len: assert property (@(posedge clock_in) disable iff (reset_in)
    (start && exposure_cycles_in == 16'h0002 && state_q != PTIC_ST_EXPOSE) ##1 !start [*2]
    |-> ($past(exposure_strobe_out) && exposure_strobe_out) ##1 !exposure_strobe_out)
    else $error("strobe width wrong");
  a_first_flag: assert property (@(posedge clock_in) disable iff (reset_in)
    first_frame_flag_out == (pattern_index_out == PAT_FIRST)) else $error("first flag mismatch");
  a_heartbeat_runs: assert property (@(posedge clock_in) disable iff (reset_in)
    (!fault_s2_q && hb_cnt_q >= HEARTBEAT_HALF - 1) |=> heartbeat_out != $past(heartbeat_out))
    else $error("heartbeat did not toggle");

endmodule : ptic_top

// [ptic_far_end.sv]
// Camera-side model that fires trigger pulses and measures the exposure strobe.
`timescale 1ns/1ps
module ptic_far_end (
  input wire logic clock_in,
  input wire logic adv_req_in,
  input wire logic hold_req_in,
  input wire logic exposure_strobe_in,
  output logic advance_trigger_out,
  output logic hold_trigger_out,
  output logic strobe_done_out,
  output logic [15:0] strobe_len_out
);
  logic [2:0] adv_q = 3'h0;
  logic [2:0] hold_q = 3'h0;
  logic [15:0] run_q = 16'h0000;
  // Pulses last four cycles so a two-stage synchroniser cannot miss them.
  // The camera shares the reference clock of the block.
  always_ff @(posedge clock_in) begin
    adv_q <= adv_req_in ? 3'h4 : adv_q - 3'(adv_q != 3'h0);
    hold_q <= hold_req_in ? 3'h4 : hold_q - 3'(hold_q != 3'h0);
    run_q <= exposure_strobe_in ? run_q + 16'h0001 : 16'h0000;
    strobe_done_out <= run_q != 16'h0000 && !exposure_strobe_in;
    if (run_q != 16'h0000 && !exposure_strobe_in) begin
      strobe_len_out <= run_q;
    end
  end
  assign advance_trigger_out = adv_q != 3'h0;
  assign hold_trigger_out = hold_q != 3'h0;
endmodule : ptic_far_end

// [pattern_trigger_illumination_ctrl_test.sv]
// Self-checking bench for the pattern trigger and illumination block.
`timescale 1ns/1ps
module pattern_trigger_illumination_ctrl_test;
  import ptic_pkg::*;
  logic clk = 1'b0, rst = 1'b1, alt = 1'b0, two = 1'b0, fault = 1'b0, areq = 1'b0, hreq = 1'b0;
  logic [5:0] last = 6'h03;
  logic [15:0] expo = 16'h0008;
  ptic_duty_s duty = '0;
  ptic_chan_s sel = '0;
  logic atrig, htrig, ren, gen, ben, rpwm, gpwm, bpwm, hb, fled, strobe, ff, sdone;
  logic [5:0] idx, prev;
  logic [15:0] slen;
  logic [5:0] exp_q[$];
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  ptic_top #(.HEARTBEAT_HALF(8)) DUT (.clock_in(clk), .reset_in(rst), .mode_alternate_in(alt),
    .hold_steps_in(two), .last_pattern_in(last), .exposure_cycles_in(expo), .duty_in(duty),
    .channel_select_in(sel), .fault_in(fault), .advance_trigger_in(atrig),
    .hold_trigger_in(htrig), .red_channel_enable_out(ren), .green_channel_enable_out(gen),
    .blue_channel_enable_out(ben), .red_current_pwm_out(rpwm), .green_current_pwm_out(gpwm),
    .blue_current_pwm_out(bpwm), .heartbeat_out(hb), .fault_led_out(fled),
    .exposure_strobe_out(strobe), .first_frame_flag_out(ff), .pattern_index_out(idx));
  ptic_far_end cam (.clock_in(clk), .adv_req_in(areq), .hold_req_in(hreq),
    .exposure_strobe_in(strobe), .advance_trigger_out(atrig), .hold_trigger_out(htrig),
    .strobe_done_out(sdone), .strobe_len_out(slen));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic do_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : do_reset
  // A note is queued only when the index is meant to move.
  task automatic trig(input bit hold, input bit note, input logic [5:0] e);
    if (note) exp_q.push_back(e);
    @(posedge clk) begin
      areq <= !hold;
      hreq <= hold;
    end
    @(posedge clk) begin
      areq <= 1'b0;
      hreq <= 1'b0;
    end
    repeat (int'(expo) + 16) @(posedge clk);
  endtask : trig
  task automatic count_hb(input int n, output int t);
    logic p;
    p = hb;
    t = 0;
    repeat (n) @(posedge clk) begin
      t += int'(hb !== p);
      p = hb;
    end
  endtask : count_hb
  // Index moves are matched in order against the queued notes.
  always @(posedge clk) begin
    if (rst) prev <= 6'h00;
    else if (idx !== prev) begin
      prev <= idx;
      if (exp_q.size() == 0) chk("index", idx, prev);
      else chk("index", idx, exp_q.pop_front());
    end
    if (!rst && idx === prev) chk("first flag", ff, idx == 6'h00);
    if (sdone) chk("strobe length", slen, expo);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    int r, g, b, t;
    void'($urandom(32'h249efa21));
    do_reset();
    chk("fault led", fled, 1'b1);
    chk("strobe idle", strobe, 1'b0);
    chk("first flag", ff, 1'b1);
    expo <= 16'(5 + $urandom % 16);
    for (int i = 1; i <= 5; i++) trig(0, 1, 6'(i % 4));
    $display("test advance done");
    alt <= 1'b1;
    // A two-cycle exposure lets the strobe width assertion see its case.
    expo <= 16'h0002;
    do_reset();
    for (int i = 1; i <= 3; i++) trig(0, 1, 6'(i % 2));
    $display("test alternate done");
    alt <= 1'b0;
    two <= 1'b1;
    last <= 6'h05;
    do_reset();
    for (int i = 1; i <= 3; i++) trig(1, 1, 6'(2 * i % 6));
    // Advance and double step on the same edge fold into one step of three.
    exp_q.push_back(6'h03);
    @(posedge clk) begin
      areq <= 1'b1;
      hreq <= 1'b1;
    end
    @(posedge clk) begin
      areq <= 1'b0;
      hreq <= 1'b0;
    end
    repeat (int'(expo) + 16) @(posedge clk);
    two <= 1'b0;
    trig(1, 0, 6'h00);
    trig(0, 0, 6'h00);
    trig(1, 0, 6'h00);
    trig(0, 1, 6'h04);
    $display("test hold done");
    duty <= 24'($urandom);
    sel <= 3'($urandom);
    repeat (300) @(posedge clk);
    r = 0;
    g = 0;
    b = 0;
    repeat (256) @(posedge clk) begin
      r += int'(rpwm);
      g += int'(gpwm);
      b += int'(bpwm);
    end
    chk("red duty", r, duty.red);
    chk("green duty", g, duty.green);
    chk("blue duty", b, duty.blue);
    chk("enables", {ren, gen, ben}, sel);
    $display("test illumination done");
    count_hb(64, t);
    chk("heartbeat", t >= 7 && t <= 9, 1'b1);
    @(posedge clk) fault <= 1'b1;
    repeat (6) @(posedge clk);
    chk("fault led", fled, 1'b0);
    chk("enables", {ren, gen, ben}, 3'h0);
    count_hb(32, t);
    chk("heartbeat frozen", t, 0);
    @(posedge clk) fault <= 1'b0;
    repeat (6) @(posedge clk);
    chk("fault led", fled, 1'b1);
    $display("test fault done");
    report_and_stop();
  end
endmodule : pattern_trigger_illumination_ctrl_test
